// ### pkg/thps_consts.svh
// Constants for the test/host port select block and its far end.
// Assumes inclusion by bare name from package and design files.
`ifndef THPS_CONSTS_SVH
`define THPS_CONSTS_SVH
`define THPS_WORD_W      16
`define THPS_ADDR_W      8
`define THPS_NREG        4
`define THPS_CFG_RST     16'h0000
`define THPS_RD_BIT      15
`define THPS_CLK_DIV     6
`define THPS_STAT_ADDR   8'h03
// Synchroniser reset image: serial in, clock and select idle high, reset pin low.
`define THPS_PIN_IDLE    7'h70
`endif

// ### pkg/thps_if.sv
// Shared pin carrier between the device end and the host/tester end.
// Assumes the bench resolves wires from the enables.
`timescale 1ns/1ps
interface thps_if;
  logic reset_n;
  logic test_sel;
  logic master_slave;
  logic rate_select;
  logic sel_pin;
  logic sclk_pin;
  logic shared_serial_in_pin;
  logic shared_serial_out_pin;
  logic shared_serial_out_oe;
  logic loop_through_output;
  logic loop_through_oe;
  modport dev
  (
    input  reset_n, test_sel, master_slave, rate_select, sel_pin, sclk_pin,
           shared_serial_in_pin,
    output shared_serial_out_pin, shared_serial_out_oe, loop_through_output,
           loop_through_oe
  );
  modport host
  (
    output reset_n, test_sel, master_slave, rate_select, sel_pin, sclk_pin,
           shared_serial_in_pin,
    input  shared_serial_out_pin, shared_serial_out_oe, loop_through_output,
           loop_through_oe
  );
endinterface

// ### pkg/thps_pkg.sv
// Types shared by both ends of the test/host port select link.
// Assumes the constants header sits beside this file.
`include "thps_consts.svh"
package thps_pkg;
  typedef logic [`THPS_WORD_W-1:0] thps_word_t;
  typedef enum logic {THPS_HOST_MODE, THPS_TEST_MODE} thps_mode_t;
  typedef enum logic [3:0] {
    THPS_TLR, THPS_RTI, THPS_SDR_SEL, THPS_CAP_DR, THPS_SH_DR, THPS_EX1_DR,
    THPS_PA_DR, THPS_EX2_DR, THPS_UPD_DR, THPS_SIR_SEL, THPS_CAP_IR,
    THPS_SH_IR, THPS_EX1_IR, THPS_PA_IR, THPS_EX2_IR, THPS_UPD_IR
  } thps_tap_t;
endpackage

// ### testbench/test_host_port_select_tb.sv
// Bench joining the device end and the host end through the pin carrier.
// Assumes the divided serial clock makes one word pair take about 2050 cycles.
`timescale 1ns/1ps
module test_host_port_select_tb;
  import thps_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       host_rst = 1'b0;
  logic       loop_data = 1'b0;
  logic       use_test = 1'b0;
  logic       slave_mode = 1'b0;
  logic       rate_in = 1'b0;
  logic       start = 1'b0;
  logic       rd = 1'b0;
  logic [1:0] addr = 2'h0;
  thps_word_t wdata = 16'h0000;
  logic       busy, done, in_reset;
  thps_mode_t mode;
  thps_tap_t  tap_state;
  thps_word_t cfg0, rdata;
  int         error_cnt = 0;
  int         n_compared = 0;
  thps_if pif();
  thps_device thps_device_i(.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .pins(pif),
    .loop_data(loop_data), .in_reset(in_reset), .mode(mode), .tap_state(tap_state),
    .cfg0(cfg0));
  thps_host thps_host_i(.clk(clk), .sys_rst(sys_rst | host_rst), .ce(1'b1), .pins(pif),
    .use_test(use_test), .slave_mode(slave_mode), .rate_in(rate_in), .start(start),
    .rd(rd), .addr(addr), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
  thps_props thps_props_i(.clk(clk), .sys_rst(sys_rst | host_rst), .reset_n(pif.reset_n),
    .test_sel(pif.test_sel), .master_slave(pif.master_slave),
    .rate_select(pif.rate_select), .sel_pin(pif.sel_pin), .sclk_pin(pif.sclk_pin),
    .shared_serial_in_pin(pif.shared_serial_in_pin),
    .shared_serial_out_pin(pif.shared_serial_out_pin),
    .shared_serial_out_oe(pif.shared_serial_out_oe), .loop_through_oe(pif.loop_through_oe));
  always #2.5 clk = ~clk;
  always @(posedge clk) loop_data <= ~loop_data;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait; a hang here is counted instead of stalling the run.
  task automatic wait_idle();
    int n;
    n = 0;
    do @(posedge clk); while (busy !== 1'b0 && ++n < 3000);
    chk(busy, 1'b0);
  endtask
  task automatic xfer(input logic r, input logic [1:0] a, input thps_word_t w);
    int n;
    n = 0;
    wait_idle();
    rd <= r;
    addr <= a;
    wdata <= w;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (done !== 1'b1 && ++n < 3000);
    chk(done, 1'b1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (10) @(posedge clk);
    chk(in_reset, 1'b1);
    chk({pif.shared_serial_out_oe, pif.loop_through_oe}, 2'b00);
    wait_idle();
    repeat (4) @(posedge clk);
    chk(in_reset, 1'b0);
    chk(mode, THPS_HOST_MODE);
    chk({pif.loop_through_oe, pif.loop_through_output ^ loop_data}, 2'b11);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    thps_word_t v[3] = '{16'hA5C3, 16'h5A3C, 16'h0FF1};
    for (int i = 0; i < 3; i++) xfer(1'b0, 2'(i), v[i]);
    chk(cfg0, v[0]);
    for (int i = 2; i >= 0; i--)
    begin
      xfer(1'b1, 2'(i), 16'h0000);
      chk(rdata, v[i]);
    end
    $display("t_regs done");
  endtask
  task automatic t_rate();
    int n;
    slave_mode <= 1'b1;
    repeat (100) @(posedge clk);
    wait_idle();
    rate_in <= 1'b1;
    n = 0;
    do @(posedge clk); while (in_reset !== 1'b1 && ++n < 200);
    chk(in_reset, 1'b1);
    xfer(1'b0, 2'h3, 16'hFFFF);
    xfer(1'b1, 2'h3, 16'h0000);
    chk(rdata, 16'h0002);
    slave_mode <= 1'b0;
    repeat (100) @(posedge clk);
    $display("t_rate done");
  endtask
  task automatic t_test();
    int seen;
    seen = 0;
    wait_idle();
    use_test <= 1'b1;
    repeat (8) @(posedge clk);
    chk(pif.test_sel, 1'b1);
    chk(mode, THPS_TEST_MODE);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2200) @(posedge clk) seen += (done === 1'b1);
    chk(seen, 0);
    host_rst <= 1'b1;
    repeat (2) @(posedge clk);
    host_rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk(in_reset, 1'b1);
    chk(tap_state, THPS_TLR);
    chk(mode, THPS_TEST_MODE);
    wait_idle();
    repeat (4) @(posedge clk);
    chk(in_reset, 1'b0);
    use_test <= 1'b0;
    repeat (8) @(posedge clk);
    chk(mode, THPS_HOST_MODE);
    $display("t_test done");
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_rate();
    t_test();
    final_report();
  end
endmodule

// ### testbench/thps_props.sv
// Checker for the shared pins between the device end and the host end.
// Assumes the bench instantiates it beside the interface joining both ends.
`timescale 1ns/1ps
module thps_props
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_n,
  input wire logic test_sel,
  input wire logic master_slave,
  input wire logic rate_select,
  input wire logic sel_pin,
  input wire logic sclk_pin,
  input wire logic shared_serial_in_pin,
  input wire logic shared_serial_out_pin,
  input wire logic shared_serial_out_oe,
  input wire logic loop_through_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Four cycles leave room for the reset pin synchroniser.
  property p_rst_hiz;
    !reset_n [*4] |-> !shared_serial_out_oe && !loop_through_oe;
  endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("pins driven in reset");
  property p_cs_idle;
    (sel_pin && !test_sel) [*4] |-> !shared_serial_out_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("out driven unselected");
  property p_sel_run;
    $fell(sel_pin) && !test_sel |-> reset_n;
  endproperty
  a_sel_run: assert property (p_sel_run) else $error("select during reset");
  property p_din_clk;
    !sel_pin && $past(!sel_pin) && !test_sel && $changed(shared_serial_in_pin) |-> !sclk_pin;
  endproperty
  a_din_clk: assert property (p_din_clk) else $error("data in moved, clock high");
  property p_dout_clk;
    shared_serial_out_oe && $past(shared_serial_out_oe) && !test_sel
      && $changed(shared_serial_out_pin) |-> !sclk_pin;
  endproperty
  a_dout_clk: assert property (p_dout_clk) else $error("data out moved, clock high");
  property p_mode_chg;
    $changed(test_sel) |-> sel_pin;
  endproperty
  a_mode_chg: assert property (p_mode_chg) else $error("mode change while selected");
  property p_sclk_low;
    $fell(sclk_pin) && !sel_pin |=> !sclk_pin [*8];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("clock low too short");
  property p_rate_rst;
    $changed(rate_select) && !master_slave |-> ##[0:16] !reset_n;
  endproperty
  a_rate_rst: assert property (p_rate_rst) else $error("no reset after rate change");
  c_xfer: cover property ($fell(sel_pin) && !test_sel);
  c_test: cover property ($rose(test_sel));
  c_rate: cover property ($changed(rate_select) && !master_slave);
endmodule

// ### verilog/thps_device.sv
// Device end: mode select, reset handling, host register shifter, scan port.
// Assumes all pins are asynchronous to clk and are synchronised here.
`timescale 1ns/1ps
`include "thps_consts.svh"
module thps_device
#(
  parameter int WORD_W = `THPS_WORD_W
)
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  thps_if.dev                  pins,
  input  wire logic            loop_data,
  output logic                 in_reset,
  output thps_pkg::thps_mode_t mode,
  output thps_pkg::thps_tap_t  tap_state,
  output thps_pkg::thps_word_t cfg0
);
  import thps_pkg::*;

  initial
  begin
    if (WORD_W != `THPS_WORD_W)
      $error("WORD_W must match the shared word type");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic       clk_prev_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Start from the idle pin levels so no false clock edge or select
      // follows reset, and keep the block in reset until the pin is seen.
      s1_q <= `THPS_PIN_IDLE;
      s2_q <= `THPS_PIN_IDLE;
    end
    else if (ce)
    begin
      s1_q <= {pins.shared_serial_in_pin, pins.sclk_pin, pins.sel_pin,
               pins.rate_select, pins.master_slave, pins.test_sel, pins.reset_n};
      s2_q <= s1_q;
    end
  end
  wire rst_n_s = s2_q[0];
  wire tsel_s  = s2_q[1];
  wire sel_s   = s2_q[4];
  wire sck_s   = s2_q[5];
  wire sdi_s   = s2_q[6];
  wire rise    = sck_s & ~clk_prev_q;
  wire fall    = ~sck_s & clk_prev_q;
  wire dev_rst = sys_rst | ~rst_n_s;

  // ------------------------------------------------------------
  // Mode and reset status
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clk_prev_q <= 1'b1;
      in_reset   <= 1'b1;
      mode       <= THPS_HOST_MODE;
    end
    else if (ce)
    begin
      clk_prev_q <= sck_s;
      in_reset   <= ~rst_n_s;
      mode       <= tsel_s ? THPS_TEST_MODE : THPS_HOST_MODE;
    end
  end

  // ------------------------------------------------------------
  // Scan controller
  // ------------------------------------------------------------
  function automatic thps_tap_t tap_next(thps_tap_t s, logic m);
    case (s)
      THPS_TLR:     tap_next = m ? THPS_TLR : THPS_RTI;
      THPS_RTI:     tap_next = m ? THPS_SDR_SEL : THPS_RTI;
      THPS_SDR_SEL: tap_next = m ? THPS_SIR_SEL : THPS_CAP_DR;
      THPS_CAP_DR:  tap_next = m ? THPS_EX1_DR : THPS_SH_DR;
      THPS_SH_DR:   tap_next = m ? THPS_EX1_DR : THPS_SH_DR;
      THPS_EX1_DR:  tap_next = m ? THPS_UPD_DR : THPS_PA_DR;
      THPS_PA_DR:   tap_next = m ? THPS_EX2_DR : THPS_PA_DR;
      THPS_EX2_DR:  tap_next = m ? THPS_UPD_DR : THPS_SH_DR;
      THPS_UPD_DR:  tap_next = m ? THPS_SDR_SEL : THPS_RTI;
      THPS_SIR_SEL: tap_next = m ? THPS_TLR : THPS_CAP_IR;
      THPS_CAP_IR:  tap_next = m ? THPS_EX1_IR : THPS_SH_IR;
      THPS_SH_IR:   tap_next = m ? THPS_EX1_IR : THPS_SH_IR;
      THPS_EX1_IR:  tap_next = m ? THPS_UPD_IR : THPS_PA_IR;
      THPS_PA_IR:   tap_next = m ? THPS_EX2_IR : THPS_PA_IR;
      THPS_EX2_IR:  tap_next = m ? THPS_UPD_IR : THPS_SH_IR;
      THPS_UPD_IR:  tap_next = m ? THPS_SIR_SEL : THPS_RTI;
      default:      tap_next = THPS_TLR;
    endcase
  endfunction

  function automatic logic tap_shifting(thps_tap_t s);
    tap_shifting = (s == THPS_SH_DR) || (s == THPS_SH_IR);
  endfunction

  // A single bypass bit stands in for the scan chain; the instruction set
  // itself lives outside this block.
  logic bypass_q;
  logic tdo_q;
  always_ff @(posedge clk)
  begin
    if (dev_rst || !tsel_s)
    begin
      tap_state <= THPS_TLR;
      bypass_q  <= 1'b0;
      tdo_q     <= 1'b0;
    end
    else if (ce)
    begin
      if (rise)
      begin
        tap_state <= tap_next(tap_state, sel_s);
        if (tap_shifting(tap_state))
          bypass_q <= sdi_s;
      end
      if (fall)
        tdo_q <= bypass_q;
    end
  end

  // ------------------------------------------------------------
  // Host register interface
  // ------------------------------------------------------------
  // Frame: one command word (read bit, address) then one data word.
  thps_word_t regs_q [`THPS_NREG];
  thps_word_t sh_q;
  thps_word_t cmd_q;
  thps_word_t rd_q;
  logic [4:0] cnt_q;
  logic       have_cmd_q;
  wire        host_act = !dev_rst && !tsel_s && !sel_s;
  wire [1:0]  widx     = cmd_q[1:0];
  wire        is_rd    = cmd_q[`THPS_RD_BIT];
  thps_word_t stat_w;
  assign stat_w = {14'h0000, s2_q[3], s2_q[2]};

  always_ff @(posedge clk)
  begin
    if (dev_rst)
    begin
      for (int i = 0; i < `THPS_NREG; i++)
        regs_q[i] <= `THPS_CFG_RST;
      sh_q       <= '0;
      cmd_q      <= '0;
      rd_q       <= '0;
      cnt_q      <= 5'h00;
      have_cmd_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!host_act)
      begin
        cnt_q      <= 5'h00;
        have_cmd_q <= 1'b0;
      end
      else if (rise)
      begin
        sh_q <= {sh_q[WORD_W-2:0], sdi_s};
        if (cnt_q == 5'(WORD_W - 1))
        begin
          cnt_q <= 5'h00;
          if (!have_cmd_q)
          begin
            cmd_q      <= {sh_q[WORD_W-2:0], sdi_s};
            have_cmd_q <= 1'b1;
            rd_q       <= ({sh_q[0], sdi_s} == 2'(`THPS_STAT_ADDR))
                          ? stat_w : regs_q[{sh_q[0], sdi_s}];
          end
          else if (!is_rd && widx != 2'(`THPS_STAT_ADDR))
            regs_q[widx] <= {sh_q[WORD_W-2:0], sdi_s};
        end
        else
          cnt_q <= cnt_q + 5'h01;
      end
      // The first falling edge of the data word must not shift, or the
      // most significant bit would be gone before the host samples it.
      else if (fall && have_cmd_q && is_rd && cnt_q != 5'h00)
        rd_q <= {rd_q[WORD_W-2:0], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // Outputs float whenever reset is low, in either mode.
  always_ff @(posedge clk)
  begin
    if (dev_rst)
    begin
      pins.shared_serial_out_pin <= 1'b0;
      pins.shared_serial_out_oe  <= 1'b0;
      pins.loop_through_output   <= 1'b0;
      pins.loop_through_oe       <= 1'b0;
      cfg0                       <= `THPS_CFG_RST;
    end
    else if (ce)
    begin
      pins.loop_through_output <= loop_data;
      pins.loop_through_oe     <= 1'b1;
      cfg0                     <= regs_q[0];
      if (tsel_s)
      begin
        pins.shared_serial_out_pin <= tdo_q;
        pins.shared_serial_out_oe  <= tap_shifting(tap_state);
      end
      else
      begin
        pins.shared_serial_out_pin <= rd_q[WORD_W-1];
        pins.shared_serial_out_oe  <= host_act && have_cmd_q && is_rd;
      end
    end
  end
endmodule

// ### verilog/thps_host.sv
// Far end: drives reset, mode and rate pins, and runs host word transfers
// with a divided serial clock. Assumes device pins settle in a few cycles.
`timescale 1ns/1ps
`include "thps_consts.svh"
module thps_host
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            ce,
  thps_if.host                 pins,
  input  wire logic            use_test,
  input  wire logic            slave_mode,
  input  wire logic            rate_in,
  input  wire logic            start,
  input  wire logic            rd,
  input  wire logic [1:0]      addr,
  input  wire thps_pkg::thps_word_t wdata,
  output logic                 busy,
  output logic                 done,
  output thps_pkg::thps_word_t rdata
);
  import thps_pkg::*;

  typedef enum logic [1:0] {THPS_H_RST, THPS_H_IDLE, THPS_H_XFER} thps_hst_t;
  thps_hst_t  st_q;
  thps_word_t sh_q;
  logic [5:0] bit_q;
  logic [`THPS_CLK_DIV-1:0] div_q;
  logic       rate_q;
  logic       sdo_s1_q;
  logic       sdo_s2_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sdo_s1_q <= 1'b0;
      sdo_s2_q <= 1'b0;
    end
    else if (ce)
    begin
      sdo_s1_q <= pins.shared_serial_out_pin;
      sdo_s2_q <= sdo_s1_q;
    end
  end

  // Reset is pulsed on a rate change in slave mode that comes while the host is idle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q                      <= THPS_H_RST;
      pins.reset_n              <= 1'b0;
      pins.test_sel             <= 1'b0;
      pins.master_slave         <= 1'b1;
      pins.rate_select          <= 1'b0;
      pins.sel_pin              <= 1'b1;
      pins.sclk_pin             <= 1'b1;
      pins.shared_serial_in_pin <= 1'b1;
      div_q  <= '0;
      bit_q  <= 6'h00;
      sh_q   <= '0;
      rate_q <= 1'b0;
      busy   <= 1'b1;
      done   <= 1'b0;
      rdata  <= '0;
    end
    else if (ce)
    begin
      done   <= 1'b0;
      div_q  <= div_q + 1'b1;
      pins.master_slave <= ~slave_mode;
      pins.rate_select  <= rate_in;
      rate_q <= rate_in;
      case (st_q)
        THPS_H_RST:
        begin
          pins.reset_n <= 1'b0;
          pins.test_sel <= use_test;
          if (&div_q)
          begin
            pins.reset_n <= 1'b1;
            st_q <= THPS_H_IDLE;
            busy <= 1'b0;
          end
        end
        THPS_H_IDLE:
        begin
          pins.test_sel <= use_test;
          if (slave_mode && rate_q != rate_in)
          begin
            st_q <= THPS_H_RST;
            div_q <= '0;
            busy <= 1'b1;
          end
          else if (start && !use_test)
          begin
            pins.sel_pin <= 1'b0;
            sh_q  <= {rd, 13'h0000, addr};
            bit_q <= 6'h00;
            div_q <= '0;
            busy  <= 1'b1;
            st_q  <= THPS_H_XFER;
          end
        end
        THPS_H_XFER:
        begin
          // Select rises half a period after the last rising edge, so the
          // device still sees that edge while it is selected.
          if (div_q == '0 && bit_q == 6'(2 * `THPS_WORD_W))
          begin
            pins.sel_pin <= 1'b1;
            st_q <= THPS_H_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
          else if (div_q == '0)
          begin
            pins.sclk_pin             <= 1'b0;
            pins.shared_serial_in_pin <= sh_q[`THPS_WORD_W-1];
          end
          else if (div_q == {1'b1, {(`THPS_CLK_DIV-1){1'b0}}})
          begin
            pins.sclk_pin <= 1'b1;
            rdata <= {rdata[`THPS_WORD_W-2:0], sdo_s2_q};
            sh_q  <= (bit_q == 6'(`THPS_WORD_W - 1)) ? wdata : {sh_q[`THPS_WORD_W-2:0], 1'b0};
            bit_q <= bit_q + 6'h01;
          end
        end
        default: st_q <= THPS_H_RST;
      endcase
    end
  end
endmodule
